// [inc/ctc_consts.vh]
// register map, field positions, reset values and timing for the compact timer
`ifndef CTC_CONSTS_VH
`define CTC_CONSTS_VH

// register byte addresses
`define CTC_ADDR_CTRL0      12'h000
`define CTC_ADDR_CTRL1      12'h004
`define CTC_ADDR_CNT_LO     12'h008
`define CTC_ADDR_CNT_HI     12'h00c
`define CTC_ADDR_MATCH_LO   12'h010
`define CTC_ADDR_MATCH_HI   12'h014
`define CTC_ADDR_STATUS     12'h018
`define CTC_ADDR_W          12

// control zero fields
`define CTC_C0_PAUSE        7
`define CTC_C0_CKSEL_HI     6
`define CTC_C0_CKSEL_LO     4
`define CTC_C0_RUN          3
`define CTC_C0_PER_HI       2
`define CTC_C0_PER_LO       0

// timer_control_one fields
`define CTC_C1_MODE_HI      7
`define CTC_C1_MODE_LO      6
`define CTC_C1_PIN_HI       5
`define CTC_C1_PIN_LO       4
`define CTC_C1_INIT         3
`define CTC_C1_INV          2
`define CTC_C1_SWAP         1
`define CTC_C1_CLRSEL       0

// status fields
`define CTC_ST_MATCH        0
`define CTC_ST_PERIOD       1

// reset values
`define CTC_RST_BYTE        8'h00
`define CTC_RST_CNT         10'h000
`define CTC_RST_PER         3'h0

// modes
`define CTC_MODE_CMP        2'h0
`define CTC_MODE_UNDEF      2'h1
`define CTC_MODE_PWM        2'h2
`define CTC_MODE_TMR        2'h3

// pin actions
`define CTC_PA_NONE         2'h0
`define CTC_PA_LOW          2'h1
`define CTC_PA_HIGH         2'h2
`define CTC_PA_TOGGLE       2'h3
`define CTC_PA_PWM          2'h2

// tick sources
`define CTC_CK_DIV4         3'h0
`define CTC_CK_DIV1         3'h1
`define CTC_CK_DIV16        3'h2
`define CTC_CK_DIV64        3'h3
`define CTC_CK_SLOW0        3'h4
`define CTC_CK_SLOW1        3'h5
`define CTC_CK_EXT_RISE     3'h6
`define CTC_CK_EXT_FALL     3'h7

// divider taps (divide by 2**(tap+1))
`define CTC_DIV_W           8
`define CTC_TAP_DIV4        1
`define CTC_TAP_DIV16       3
`define CTC_TAP_DIV64       5
`define CTC_TAP_SLOW        7

// counter geometry
`define CTC_CNT_W           10
`define CTC_PER_SHIFT       7
`define CTC_FULL_COUNT      11'h400

`endif

// [hw/ctc_tick_gen.v]
// timer tick enable generator: internal divider or external pin edge
`timescale 1ns/100ps
`include "ctc_consts.vh"

module ctc_tick_gen (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // selection
   input  wire [2:0]  tick_sel,
   input  wire        ext_tick_in,
   // tick enable pulse
   output reg         tick_reg
);

   reg [`CTC_DIV_W-1:0] div_reg;
   reg                  ext_prev_reg;
   reg [`CTC_DIV_W-1:0] div_next;
   reg                  tick_next;

   always @* begin
      div_next = div_reg + 1'b1;
      case (tick_sel)
         `CTC_CK_DIV4:     tick_next = &div_reg[`CTC_TAP_DIV4:0];
         `CTC_CK_DIV1:     tick_next = 1'b1;
         `CTC_CK_DIV16:    tick_next = &div_reg[`CTC_TAP_DIV16:0];
         `CTC_CK_DIV64:    tick_next = &div_reg[`CTC_TAP_DIV64:0];
         `CTC_CK_SLOW0,
         `CTC_CK_SLOW1:    tick_next = &div_reg[`CTC_TAP_SLOW:0];
         `CTC_CK_EXT_RISE: tick_next = ext_tick_in & ~ext_prev_reg;
         `CTC_CK_EXT_FALL: tick_next = ~ext_tick_in & ext_prev_reg;
         default:          tick_next = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg      <= {`CTC_DIV_W{1'b0}};
         ext_prev_reg <= 1'b0;
         tick_reg     <= 1'b0;
      end else begin
         div_reg      <= div_next;
         ext_prev_reg <= ext_tick_in;
         tick_reg     <= tick_next;
      end
   end

endmodule

// [hw/ctc_compare.v]
// comparators p and a plus pwm duty compare
`timescale 1ns/100ps
`include "ctc_consts.vh"

module ctc_compare (
   // counter and settings
   input  wire [9:0]  count,
   input  wire [2:0]  period_compare_bits,
   input  wire [9:0]  match_compare_value,
   input  wire        period_duty_swap,
   // results for the next count value, duty for the present one
   output wire [10:0] count_inc,
   output wire        period_hit,
   output wire        match_hit,
   output wire        duty_active
);

   wire [10:0] period_value;
   wire [10:0] duty_value;

   assign count_inc    = {1'b0, count} + 11'h001;
   // field zero means full 1024 ticks, else multiples of 128
   assign period_value = (period_compare_bits == `CTC_RST_PER) ? `CTC_FULL_COUNT :
                         {1'b0, period_compare_bits, {`CTC_PER_SHIFT{1'b0}}};
   assign period_hit   = (count_inc == period_value);
   // all ten bits compared; zero value never flags
   assign match_hit    = (match_compare_value != `CTC_RST_CNT) &&
                         (count_inc == {1'b0, match_compare_value});
   // swap selects which value gives the duty
   assign duty_value   = period_duty_swap ? period_value : {1'b0, match_compare_value};
   assign duty_active  = ({1'b0, count} < duty_value);

endmodule

// [hw/ctc_top.v]
// compact 10-bit timer with apb register file and one output pin
//
// Summary of operation
// - period bits match counter top three bits
// - clear select zero clears on period match
// - period zero lets counter overflow
// - mode field: compare, undefined, pwm, timer
// - compare mode applies pin action on match
// - pwm pin action: inactive, active, waveform
// - equal requested level leaves pin unchanged
// - run rising edge restores initial pin level
// - initial level bit: start level, pwm polarity
// - invert bit inverts pin in compare and pwm modes
// - swap bit exchanges period and duty roles
// - clear select one clears on match value
// - pwm ignores clear select, follows swap
// - counter low byte readable, resets zero
// - counter high byte two bits, rest zero
// - match low byte read/write, resets zero
// - run rise zeroes counter, fall holds it
// - match compares all ten counter bits
// - match high byte two bits read/write
// - match clear raises only match flag; pwm swap clear still raises period flag on period hit
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "ctc_consts.vh"

module ctc_top (
   // apb clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg         pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   // external tick input
   input  wire        ext_tick_in,
   // timer output pin
   output reg         timer_output_pin,
   output reg         timer_output_pin_oe
);

   // registers
   reg        pause_reg;
   reg [2:0]  tick_sel_reg;
   reg        counter_run_reg;
   reg [2:0]  period_compare_bits_reg;
   reg [7:0]  timer_control_one_reg;
   reg [7:0]  match_value_low_byte_reg;
   reg [1:0]  match_value_high_byte_reg;
   reg        match_event_flag_reg;
   reg        period_event_flag_reg;
   reg [9:0]  count_reg;
   reg        run_prev_reg;
   reg        cmp_level_reg;

   // next values
   reg [9:0]  count_next;
   reg        cmp_level_next;
   reg        pin_next;
   reg        pin_oe_next;
   reg        match_flag_next;
   reg        period_flag_next;
   reg [31:0] rdata_next;
   reg        addr_ok;

   // internal
   wire        tick;
   wire [10:0] count_inc;
   wire        period_hit_raw;
   wire        match_hit_raw;
   wire        duty_active;
   wire [9:0]  match_compare_value;
   wire [1:0]  mode_select;
   wire [1:0]  pin_action;
   wire        output_initial_level;
   wire        output_invert;
   wire        period_duty_swap;
   wire        clear_source_select;
   wire        pwm_mode;
   wire        clear_on_match;
   wire        step;
   wire        run_rise;
   wire        period_hit;
   wire        match_hit;
   wire        apb_access;
   wire        apb_write;

   assign mode_select          = timer_control_one_reg[`CTC_C1_MODE_HI:`CTC_C1_MODE_LO];
   assign pin_action           = timer_control_one_reg[`CTC_C1_PIN_HI:`CTC_C1_PIN_LO];
   assign output_initial_level = timer_control_one_reg[`CTC_C1_INIT];
   assign output_invert        = timer_control_one_reg[`CTC_C1_INV];
   assign period_duty_swap     = timer_control_one_reg[`CTC_C1_SWAP];
   assign clear_source_select  = timer_control_one_reg[`CTC_C1_CLRSEL];
   assign match_compare_value  = {match_value_high_byte_reg, match_value_low_byte_reg};

   assign pwm_mode       = (mode_select == `CTC_MODE_PWM);
   // pwm clears by the swap choice, otherwise by the clear select
   assign clear_on_match = pwm_mode ? period_duty_swap : clear_source_select;
   assign run_rise       = counter_run_reg & ~run_prev_reg;
   assign step           = counter_run_reg & ~pause_reg & tick & ~run_rise;
   assign period_hit     = step & period_hit_raw;
   assign match_hit      = step & match_hit_raw;

   assign apb_access = psel & penable & pready;
   assign apb_write  = apb_access & pwrite & addr_ok;

   ctc_tick_gen u_tick (
      .pclk        (pclk),
      .presetn     (presetn),
      .tick_sel    (tick_sel_reg),
      .ext_tick_in (ext_tick_in),
      .tick_reg    (tick)
   );

   ctc_compare u_cmp (
      .count               (count_reg),
      .period_compare_bits (period_compare_bits_reg),
      .match_compare_value (match_compare_value),
      .period_duty_swap    (period_duty_swap),
      .count_inc           (count_inc),
      .period_hit          (period_hit_raw),
      .match_hit           (match_hit_raw),
      .duty_active         (duty_active)
   );

   // counter
   always @* begin
      count_next = count_reg;
      if (run_rise) begin
         count_next = `CTC_RST_CNT;
      end else if (step) begin
         if (clear_on_match ? match_hit : period_hit) begin
            count_next = `CTC_RST_CNT;
         end else begin
            count_next = count_inc[9:0];
         end
      end
   end

   // event flags, set wins over clear
   always @* begin
      match_flag_next  = match_event_flag_reg;
      period_flag_next = period_event_flag_reg;
      if (apb_write && paddr == `CTC_ADDR_STATUS) begin
         if (pwdata[`CTC_ST_MATCH]) begin
            match_flag_next = 1'b0;
         end
         if (pwdata[`CTC_ST_PERIOD]) begin
            period_flag_next = 1'b0;
         end
      end
      if (match_hit) begin
         match_flag_next = 1'b1;
      end
      // clear select one outside pwm raises no period flag
      if (period_hit && (pwm_mode || !clear_source_select)) begin
         period_flag_next = 1'b1;
      end
   end

   // compare mode pin level and pin drive
   always @* begin
      cmp_level_next = cmp_level_reg;
      if (run_rise) begin
         cmp_level_next = output_initial_level;
      end else if (match_hit && mode_select == `CTC_MODE_CMP) begin
         // requested level equal to present leaves it as is
         case (pin_action)
            `CTC_PA_NONE:   cmp_level_next = cmp_level_reg;
            `CTC_PA_LOW:    cmp_level_next = 1'b0;
            `CTC_PA_HIGH:   cmp_level_next = 1'b1;
            `CTC_PA_TOGGLE: cmp_level_next = ~cmp_level_reg;
            default:        cmp_level_next = cmp_level_reg;
         endcase
      end
      pin_next    = 1'b0;
      pin_oe_next = 1'b0;
      case (mode_select)
         `CTC_MODE_CMP: begin
            pin_next    = cmp_level_next ^ output_invert;
            pin_oe_next = 1'b1;
         end
         `CTC_MODE_PWM: begin
            // oc gives the active level
            case (pin_action)
               `CTC_PA_NONE: pin_next = ~output_initial_level;
               `CTC_PA_LOW:  pin_next = output_initial_level;
               `CTC_PA_PWM:  pin_next = duty_active ? output_initial_level
                                                    : ~output_initial_level;
               default:      pin_next = ~output_initial_level;
            endcase
            pin_next    = pin_next ^ output_invert;
            pin_oe_next = 1'b1;
         end
         default: begin
            // timer mode leaves the pin unused
            pin_next    = 1'b0;
            pin_oe_next = 1'b0;
         end
      endcase
   end

   // apb read mux and address decode
   always @* begin
      addr_ok    = 1'b1;
      rdata_next = 32'h0000_0000;
      case (paddr)
         `CTC_ADDR_CTRL0: begin
            rdata_next[`CTC_C0_PAUSE]                    = pause_reg;
            rdata_next[`CTC_C0_CKSEL_HI:`CTC_C0_CKSEL_LO] = tick_sel_reg;
            rdata_next[`CTC_C0_RUN]                      = counter_run_reg;
            rdata_next[`CTC_C0_PER_HI:`CTC_C0_PER_LO]    = period_compare_bits_reg;
         end
         `CTC_ADDR_CTRL1:    rdata_next[7:0] = timer_control_one_reg;
         `CTC_ADDR_CNT_LO:   rdata_next[7:0] = count_reg[7:0];
         `CTC_ADDR_CNT_HI:   rdata_next[1:0] = count_reg[9:8];
         `CTC_ADDR_MATCH_LO: rdata_next[7:0] = match_value_low_byte_reg;
         `CTC_ADDR_MATCH_HI: rdata_next[1:0] = match_value_high_byte_reg;
         `CTC_ADDR_STATUS: begin
            rdata_next[`CTC_ST_MATCH]  = match_event_flag_reg;
            rdata_next[`CTC_ST_PERIOD] = period_event_flag_reg;
         end
         default:            addr_ok = 1'b0;
      endcase
   end

   // apb handshake: one wait state, then answer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         if (psel && penable && !pready) begin
            prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
            pslverr <= ~addr_ok;
         end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
         end
      end
   end

   // register writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pause_reg                 <= 1'b0;
         tick_sel_reg              <= `CTC_CK_DIV4;
         counter_run_reg           <= 1'b0;
         period_compare_bits_reg   <= `CTC_RST_PER;
         timer_control_one_reg     <= `CTC_RST_BYTE;
         match_value_low_byte_reg  <= `CTC_RST_BYTE;
         match_value_high_byte_reg <= 2'h0;
      end else if (apb_write) begin
         case (paddr)
            `CTC_ADDR_CTRL0: begin
               pause_reg               <= pwdata[`CTC_C0_PAUSE];
               tick_sel_reg            <= pwdata[`CTC_C0_CKSEL_HI:`CTC_C0_CKSEL_LO];
               counter_run_reg         <= pwdata[`CTC_C0_RUN];
               period_compare_bits_reg <= pwdata[`CTC_C0_PER_HI:`CTC_C0_PER_LO];
            end
            `CTC_ADDR_CTRL1:    timer_control_one_reg     <= pwdata[7:0];
            `CTC_ADDR_MATCH_LO: match_value_low_byte_reg  <= pwdata[7:0];
            `CTC_ADDR_MATCH_HI: match_value_high_byte_reg <= pwdata[1:0];
            default: begin
               pause_reg <= pause_reg;
            end
         endcase
      end
   end

   // timer state
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg             <= `CTC_RST_CNT;
         run_prev_reg          <= 1'b0;
         cmp_level_reg         <= 1'b0;
         match_event_flag_reg  <= 1'b0;
         period_event_flag_reg <= 1'b0;
         timer_output_pin      <= 1'b0;
         timer_output_pin_oe   <= 1'b0;
      end else begin
         count_reg             <= count_next;
         run_prev_reg          <= counter_run_reg;
         cmp_level_reg         <= cmp_level_next;
         match_event_flag_reg  <= match_flag_next;
         period_event_flag_reg <= period_flag_next;
         timer_output_pin      <= pin_next;
         timer_output_pin_oe   <= pin_oe_next;
      end
   end

endmodule

// [testbench/ctc_load_model.sv]
// load on the timer pin: pulled low when released, counts edges and high cycles
`timescale 1ns/100ps

module ctc_load_model (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // timer pin
   input  wire        pin,
   input  wire        oe,
   // observed level and statistics
   output wire        level,
   output reg  [15:0] edge_cnt,
   output reg  [15:0] high_cnt
);
   reg last_reg;

   // pull-down holds a released pin low
   assign level = oe ? pin : 1'b0;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_reg <= 1'b0;
         edge_cnt <= 16'h0;
         high_cnt <= 16'h0;
      end else begin
         last_reg <= level;
         if (level != last_reg) edge_cnt <= edge_cnt + 16'h1;
         if (level) high_cnt <= high_cnt + 16'h1;
      end
   end
endmodule

// [testbench/ctc_chk_asserts.sv]
// checker for apb answers, register shadows and timer pin levels
`timescale 1ns/100ps
`include "ctc_consts.vh"

module ctc_chk_asserts (
   // apb clock and reset
   input wire        pclk,
   input wire        presetn,
   // apb slave
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire [31:0] prdata,
   input wire        pslverr,
   // tick and pin
   input wire        ext_tick_in,
   input wire        timer_output_pin,
   input wire        timer_output_pin_oe
);
   reg  [7:0]  c0_reg, c1_reg, c0_prev_reg, c1_prev_reg, mlo_reg;
   reg  [1:0]  mhi_reg;
   reg  [2:0]  quiet_reg;
   wire        wr_done = psel && penable && pready && pwrite;
   wire        settled = (quiet_reg > 3'h3) && (c0_reg == c0_prev_reg) &&
                         (c1_reg == c1_prev_reg);
   wire [1:0]  mode    = c1_reg[7:6];
   wire [31:0] shadow  = (paddr == `CTC_ADDR_CTRL1) ? {24'h0, c1_reg} :
                         (paddr == `CTC_ADDR_MATCH_LO) ? {24'h0, mlo_reg} : {30'h0, mhi_reg};

   // shadow copies of the writable settings
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c0_reg <= 8'h00;
         c1_reg <= 8'h00;
         c0_prev_reg <= 8'h00;
         c1_prev_reg <= 8'h00;
         mlo_reg <= 8'h00;
         mhi_reg <= 2'h0;
         quiet_reg <= 3'h0;
      end else begin
         c0_prev_reg <= c0_reg;
         c1_prev_reg <= c1_reg;
         quiet_reg <= (c0_reg != c0_prev_reg || c1_reg != c1_prev_reg) ? 3'h0 :
                      (quiet_reg == 3'h7) ? 3'h7 : quiet_reg + 3'h1;
         if (wr_done && paddr == `CTC_ADDR_CTRL0) c0_reg <= pwdata[7:0];
         if (wr_done && paddr == `CTC_ADDR_CTRL1) c1_reg <= pwdata[7:0];
         if (wr_done && paddr == `CTC_ADDR_MATCH_LO) mlo_reg <= pwdata[7:0];
         if (wr_done && paddr == `CTC_ADDR_MATCH_HI) mhi_reg <= pwdata[1:0];
      end
   end

   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not answered after one wait");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   chk_err_decode: assert property (pready && paddr[1:0] == 2'h0 |->
      pslverr == (paddr > `CTC_ADDR_STATUS)) else $error("wrong error decode");
   chk_cnt_hi_zero: assert property (pready && !pwrite &&
      paddr == `CTC_ADDR_CNT_HI |-> prdata[31:2] == 30'h0) else $error("high byte bits set");
   chk_shadow_read: assert property (pready && !pwrite &&
      (paddr == `CTC_ADDR_CTRL1 || paddr == `CTC_ADDR_MATCH_LO || paddr == `CTC_ADDR_MATCH_HI)
      |-> prdata == shadow) else $error("read data differs from written value");
   chk_oe_drive: assert property (settled && c0_reg[3] && !mode[0] |->
      timer_output_pin_oe) else $error("pin not driven in output mode");
   chk_oe_quiet: assert property (settled && mode[0] |-> !timer_output_pin_oe &&
      (mode == `CTC_MODE_UNDEF || !timer_output_pin)) else $error("pin driven in timer mode");
   chk_pwm_force: assert property (settled && c0_reg[3] && mode == `CTC_MODE_PWM &&
      c1_reg[5:4] != `CTC_PA_PWM |-> timer_output_pin ==
      (c1_reg[3] ^ c1_reg[2] ^ (c1_reg[5:4] != `CTC_PA_LOW))) else $error("forced level wrong");
   chk_cmp_hold: assert property (settled && mode == `CTC_MODE_CMP &&
      c1_reg[5:4] == `CTC_PA_NONE |-> $stable(timer_output_pin)) else $error("pin moved");
   chk_run_restore: assert property (c0_reg[3] && !c0_prev_reg[3] &&
      mode == `CTC_MODE_CMP |-> ##[1:3] timer_output_pin == (c1_reg[3] ^ c1_reg[2]))
      else $error("pin not restored on run start");
endmodule

// [testbench/compact_timer_control_tb_top.sv]
// directed testbench for the compact timer over apb
`timescale 1ns/100ps
`include "ctc_consts.vh"

module compact_timer_control_tb_top;
   localparam [47:0] CMPC  = {8'h30, 8'h24, 8'h10, 8'h18, 8'h28, 8'h20};
   localparam [5:0]  LVL   = 6'b000011;
   localparam [5:0]  MOVED = 6'b110101;
   localparam [47:0] PWMC  = {8'h90, 8'h98, 8'h88, 8'had, 8'haa, 8'ha9};
   localparam [59:0] PEXP  = {10'd0, 10'd256, 10'd0, 10'd192, 10'd256, 10'd64};
   reg         pclk, presetn, psel, penable, pwrite, ext_tick_in, err_bit;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd, mx, v;
   reg  [15:0] e0, h0;
   reg  [7:0]  c1v;
   wire        pready, pslverr, timer_output_pin, timer_output_pin_oe, load_lvl;
   wire [31:0] prdata;
   wire [15:0] edge_cnt, high_cnt;
   integer     fail_count, checks_done, i;

   ctc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .ext_tick_in, .timer_output_pin, .timer_output_pin_oe);
   ctc_load_model load (.pclk, .presetn, .pin(timer_output_pin),
      .oe(timer_output_pin_oe), .level(load_lvl), .edge_cnt, .high_cnt);

   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", checks_done, fail_count);
         if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask

   task chk(input [31:0] got, input [31:0] exp, input [8*12-1:0] what);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH t=%0t %0s got %h exp %h", $time, what, got, exp);
         end
      end
   endtask

   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         // look mid-cycle, where the registered answer has settled
         @(negedge pclk);
         while (pready !== 1'b1 && n < 20) begin
            n = n + 1;
            @(negedge pclk);
         end
         if (n == 20) chk(32'h0, 32'h1, "apb hang");
         rd = prdata;
         err_bit = pslverr;
         // hold the request through the edge that samples pready high
         @(posedge pclk);
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task wr(input [11:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdc(input [11:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         chk(rd, exp, "read");
      end
   endtask

   task cfg(input [7:0] c1, input [7:0] c0);
      begin
         wr(`CTC_ADDR_CTRL0, {24'h0, c0 & 8'hf7}); // timer off first
         wr(`CTC_ADDR_CTRL1, {24'h0, c1});
         wr(`CTC_ADDR_CTRL0, {24'h0, c0});
      end
   endtask

   task per_run(input [7:0] c1, input [2:0] f, input [11:0] a, input integer n,
                input [31:0] mask, input [31:0] exp);
      integer k;
      begin
         cfg(c1, {5'h03, f});
         mx = 32'h0;
         for (k = 0; k < n; k = k + 1) begin
            apb(1'b0, a, 32'h0);
            if (rd > mx) mx = rd;
         end
         chk(mx & mask, exp, "counter top");
      end
   endtask

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial begin
      #500000;
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t watchdog expired", $time);
      wrap_up;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      ext_tick_in = 1'b0;
      fail_count = 0;
      checks_done = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 7; i = i + 1) rdc(12'(4 * i), 32'h0);
      apb(1'b0, 12'h01c, 32'h0);
      chk({31'h0, err_bit}, 32'h1, "unmapped");
      wr(`CTC_ADDR_MATCH_LO, 32'hffff_ffa5);
      wr(`CTC_ADDR_MATCH_HI, 32'hffff_ffff);
      wr(`CTC_ADDR_CNT_LO, 32'h0000_00ff);
      wr(`CTC_ADDR_CTRL1, 32'h0000_005a);
      rdc(`CTC_ADDR_MATCH_LO, 32'ha5);
      rdc(`CTC_ADDR_MATCH_HI, 32'h3);
      rdc(`CTC_ADDR_CNT_LO, 32'h0);
      rdc(`CTC_ADDR_CTRL1, 32'h5a);
      $display("test registers done");
      per_run(8'h00, 3'h1, `CTC_ADDR_CNT_LO, 80, 32'hf8, 32'h78);
      per_run(8'h00, 3'h3, `CTC_ADDR_CNT_HI, 120, 32'hff, 32'h1);
      per_run(8'h00, 3'h0, `CTC_ADDR_CNT_HI, 300, 32'hff, 32'h3);
      wr(`CTC_ADDR_MATCH_LO, 32'h0);
      wr(`CTC_ADDR_MATCH_HI, 32'h1);
      per_run(8'h01, 3'h1, `CTC_ADDR_CNT_LO, 150, 32'hf8, 32'hf8);
      wr(`CTC_ADDR_STATUS, 32'h3);
      repeat (300) @(posedge pclk);
      rdc(`CTC_ADDR_STATUS, 32'h1);
      wr(`CTC_ADDR_CTRL0, 32'h11);
      apb(1'b0, `CTC_ADDR_CNT_LO, 32'h0);
      v = rd;
      repeat (20) @(posedge pclk);
      rdc(`CTC_ADDR_CNT_LO, v);
      wr(`CTC_ADDR_CTRL0, 32'h19);
      apb(1'b0, `CTC_ADDR_CNT_LO, 32'h0);
      chk(rd & 32'hf0, 32'h0, "restart");
      cfg(8'h00, 8'h68);
      rdc(`CTC_ADDR_CNT_LO, 32'h0);
      repeat (5) begin
         @(posedge pclk);
         ext_tick_in <= 1'b1;
         repeat (4) @(posedge pclk);
         ext_tick_in <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      rdc(`CTC_ADDR_CNT_LO, 32'h5);
      $display("test counter done");
      wr(`CTC_ADDR_MATCH_LO, 32'h10);
      wr(`CTC_ADDR_MATCH_HI, 32'h0);
      for (i = 0; i < 6; i = i + 1) begin
         cfg(CMPC[8*i +: 8] | 8'h01, 8'h18);
         repeat (3) @(posedge pclk);
         e0 = edge_cnt;
         repeat (100) @(posedge pclk);
         chk({31'h0, edge_cnt !== e0}, {31'h0, MOVED[i]}, "pin moved");
         if (i < 5) chk({31'h0, load_lvl}, {31'h0, LVL[i]}, "pin level");
      end
      $display("test compare done");
      for (i = 0; i < 6; i = i + 1) begin
         c1v = PWMC[8*i +: 8];
         wr(`CTC_ADDR_MATCH_LO, c1v[1] ? 32'h0 : 32'h20);
         wr(`CTC_ADDR_MATCH_HI, c1v[1] ? 32'h1 : 32'h0);
         cfg(c1v, 8'h19);
         repeat (8) @(posedge pclk);
         h0 = high_cnt;
         repeat (c1v[1] ? 512 : 256) @(posedge pclk);
         chk({16'h0, high_cnt - h0}, {22'h0, PEXP[10*i +: 10]}, "pwm highs");
      end
      $display("test pwm done");
      for (i = 0; i < 2; i = i + 1) begin
         cfg(i == 0 ? 8'hc4 : 8'h44, 8'h19);
         repeat (8) @(posedge pclk);
         chk({31'h0, timer_output_pin_oe}, 32'h0, "pin enable");
      end
      $display("test timer mode done");
      wrap_up;
   end
endmodule

bind ctc_top ctc_chk_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .prdata, .pslverr, .ext_tick_in, .timer_output_pin, .timer_output_pin_oe);
